// ### hw/pecu_top.sv
// Performance event counter unit with APB register access
// Behaviour
// - Run-to-break mode counts from program start until any break halts execution.
// - Forward trigger mode counts from first trigger until second trigger.
// - Reverse trigger mode counts from second trigger until first trigger.
// - Window mode has exactly three choices: run-break, forward, reverse.
// - Four channels count their own events in the same window.
// - Each channel selects disabled or one of the listed event sources.
// - DSP and TLB-miss sources count only when that unit is present.
// - Trigger modes need one enabled channel; otherwise arming is an error.
// - Counts may be slightly off around the start and stop events.
// - Counters run on the CPU clock and stop at the selected mode's stop event or at a host initialize request.
// - Results are 32 bits and overflow is visible to the host.
// - A branch adds two to the counter.
// - Host initialize request clears all channel results.
`timescale 1ns/1ps
module pecu_top
	import pecu_pkg::*;
#(
	parameter bit HAS_DSP = 1'b1,
	parameter bit HAS_MMU = 1'b1
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [PECU_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RUN_START,
	input wire logic BREAK_HALT,
	input wire logic TRIG_A,
	input wire logic TRIG_B,
	input wire logic [PECU_EVT_N-1:0] EVENTS,
	output logic COUNTING
);
	if (PECU_CH_N != 4) begin : g_ch_check
		$error("pecu_top serves exactly four channels");
	end

	typedef struct packed {
		pecu_mode_t mode;
		logic armed;
		logic counting;
		logic err;
		logic done;
		logic [PECU_CH_N-1:0][PECU_SRC_W-1:0] sel;
		logic [PECU_CH_N-1:0][31:0] cnt;
		logic [PECU_CH_N-1:0] ovf;
		logic [31:0] rdata;
	} pecu_state_t;

	pecu_state_t st;
	pecu_state_t next_st;
	logic wr;
	logic rd;
	logic start_ev;
	logic stop_ev;
	logic any_ch;
	logic [PECU_CH_N-1:0] hit;
	logic [32:0] sum;
	logic [31:0] wmode;
	// Unused source codes read as zero instead of indexing past the event bus
	logic [(1 << PECU_SRC_W)-1:0] ev_ext;

	assign ev_ext = {{((1 << PECU_SRC_W) - PECU_EVT_N){1'b0}}, EVENTS};
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = st.rdata;
	assign COUNTING = st.counting;

	always_comb begin
		any_ch = 1'b0;
		for (int c = 0; c < PECU_CH_N; c++) begin
			any_ch = any_ch | (st.sel[c] != PECU_SRC_W'(PECU_SRC_DISABLED));
		end
		unique case (st.mode)
			PECU_MODE_RUN_BREAK: begin
				start_ev = RUN_START;
				stop_ev = BREAK_HALT;
			end
			PECU_MODE_TRIG_FWD: begin
				start_ev = TRIG_A;
				stop_ev = TRIG_B;
			end
			PECU_MODE_TRIG_REV: begin
				start_ev = TRIG_B;
				stop_ev = TRIG_A;
			end
			default: begin
				start_ev = 1'b0;
				stop_ev = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		sum = '0;
		wmode = PWDATA >> PECU_CTRL_MODE_LSB;
		hit = '0;
		// Start/stop are sampled the cycle they occur; a one-cycle skew is accepted
		if (st.armed && !st.counting && start_ev) begin
			next_st.counting = 1'b1;
		end
		if (st.counting && stop_ev) begin
			next_st.counting = 1'b0;
			next_st.armed = 1'b0;
			next_st.done = 1'b1;
		end
		for (int c = 0; c < PECU_CH_N; c++) begin
			unique case (pecu_src_t'(st.sel[c]))
				PECU_SRC_DISABLED: hit[c] = 1'b0;
				PECU_SRC_DSP_OP: hit[c] = HAS_DSP && EVENTS[PECU_SRC_DSP_OP];
				PECU_SRC_OPERAND_TLB_MISS, PECU_SRC_FETCH_TLB_MISS: begin
					hit[c] = HAS_MMU && EVENTS[st.sel[c]];
				end
				default: hit[c] = ev_ext[st.sel[c]];
			endcase
			if (st.counting && hit[c]) begin
				sum = {1'b0, st.cnt[c]} + ((st.sel[c] == PECU_SRC_W'(PECU_SRC_BRANCH)) ? PECU_INC_TWO : PECU_INC_ONE);
				next_st.cnt[c] = sum[31:0];
				next_st.ovf[c] = st.ovf[c] | sum[32];
			end
		end
		if (wr) begin
			if (PADDR == PECU_CTRL_OFS) begin
				if (wmode[1:0] <= 2'(PECU_MODE_TRIG_REV)) begin
					next_st.mode = pecu_mode_t'(wmode[1:0]);
				end
				if (PWDATA[PECU_CTRL_INIT_BIT]) begin
					next_st.cnt = '0;
					next_st.ovf = '0;
					next_st.done = 1'b0;
					next_st.counting = 1'b0;
					next_st.armed = 1'b0;
				end
				if (PWDATA[PECU_CTRL_ARM_BIT]) begin
					// Judged on the mode written in this same access
					if (next_st.mode != PECU_MODE_RUN_BREAK && !any_ch) begin
						next_st.err = 1'b1;
						next_st.armed = 1'b0;
					end else begin
						next_st.err = 1'b0;
						next_st.armed = 1'b1;
						next_st.done = 1'b0;
					end
				end
			end else if (PADDR == PECU_SEL_OFS && !st.counting) begin
				for (int c = 0; c < PECU_CH_N; c++) begin
					next_st.sel[c] = PWDATA[c*PECU_SEL_STRIDE +: PECU_SRC_W];
				end
			end
		end
		if (rd) begin
			next_st.rdata = PECU_ZERO;
			if (PADDR == PECU_CTRL_OFS) begin
				next_st.rdata[PECU_CTRL_MODE_LSB +: 2] = st.mode;
				next_st.rdata[PECU_CTRL_ARM_BIT] = st.armed;
			end else if (PADDR == PECU_STATUS_OFS) begin
				next_st.rdata[PECU_ST_COUNT_BIT] = st.counting;
				next_st.rdata[PECU_ST_ERR_BIT] = st.err;
				next_st.rdata[PECU_ST_DONE_BIT] = st.done;
				next_st.rdata[PECU_ST_OVF_LSB +: PECU_CH_N] = st.ovf;
			end else if (PADDR == PECU_SEL_OFS) begin
				for (int c = 0; c < PECU_CH_N; c++) begin
					next_st.rdata[c*PECU_SEL_STRIDE +: PECU_SRC_W] = st.sel[c];
				end
			end else begin
				for (int c = 0; c < PECU_CH_N; c++) begin
					if (PADDR == PECU_CNT0_OFS + 8'(4 * c)) begin
						next_st.rdata = st.cnt[c];
					end
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	property p_stop_ends;
		@(posedge CLK) disable iff (SRST)
		(st.counting && stop_ev && !wr) |=> (!st.counting && st.done);
	endproperty
	a_stop_ends: assert property (p_stop_ends) else $error("stop event did not end window");

	property p_fwd_start;
		@(posedge CLK) disable iff (SRST)
		(st.mode == PECU_MODE_TRIG_FWD && st.armed && !st.counting && TRIG_A && !wr) |=> st.counting;
	endproperty
	a_fwd_start: assert property (p_fwd_start) else $error("forward trigger did not start");

	property p_rev_start;
		@(posedge CLK) disable iff (SRST)
		(st.mode == PECU_MODE_TRIG_REV && st.armed && !st.counting && TRIG_B && !wr) |=> st.counting;
	endproperty
	a_rev_start: assert property (p_rev_start) else $error("reverse trigger did not start");

	property p_run_start;
		@(posedge CLK) disable iff (SRST)
		(st.mode == PECU_MODE_RUN_BREAK && st.armed && !st.counting && RUN_START && !wr) |=> st.counting;
	endproperty
	a_run_start: assert property (p_run_start) else $error("run start did not start");

	property p_mode_legal;
		@(posedge CLK) disable iff (SRST) st.mode != 2'h3;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("illegal window mode");

	property p_hold;
		@(posedge CLK) disable iff (SRST)
		(!st.counting && !wr) |=> (st.cnt == $past(st.cnt));
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved outside window");

	property p_branch_two;
		@(posedge CLK) disable iff (SRST)
		(st.counting && !stop_ev && !wr && st.sel[PECU_CH_N-1] == PECU_SRC_W'(PECU_SRC_BRANCH)
			&& EVENTS[PECU_SRC_BRANCH])
		|=> (st.cnt[PECU_CH_N-1] == $past(st.cnt[PECU_CH_N-1]) + 32'h00000002);
	endproperty
	a_branch_two: assert property (p_branch_two) else $error("branch did not add two");

	property p_init_clears;
		@(posedge CLK) disable iff (SRST)
		(wr && PADDR == PECU_CTRL_OFS && PWDATA[PECU_CTRL_INIT_BIT]) |=> (st.cnt == '0 && st.ovf == '0);
	endproperty
	a_init_clears: assert property (p_init_clears) else $error("init did not clear results");

	property p_no_ch_err;
		@(posedge CLK) disable iff (SRST)
		(wr && PADDR == PECU_CTRL_OFS && PWDATA[PECU_CTRL_ARM_BIT] && !any_ch
			&& (PWDATA[PECU_CTRL_MODE_LSB +: 2] == 2'(PECU_MODE_TRIG_FWD)
			|| PWDATA[PECU_CTRL_MODE_LSB +: 2] == 2'(PECU_MODE_TRIG_REV)))
		|=> (st.err && !st.armed);
	endproperty
	a_no_ch_err: assert property (p_no_ch_err) else $error("empty trigger config not refused");

	property p_ovf_sticky;
		@(posedge CLK) disable iff (SRST)
		(st.ovf[0] && !wr) |=> st.ovf[0];
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
endmodule : pecu_top

// ### hw/pecu_pkg.sv
// Package for the performance event counter unit: map, fields, sources
package pecu_pkg;
	localparam int PECU_ADDR_W = 8;
	localparam logic [7:0] PECU_CTRL_OFS = 8'h00;
	localparam logic [7:0] PECU_STATUS_OFS = 8'h04;
	localparam logic [7:0] PECU_SEL_OFS = 8'h08;
	localparam logic [7:0] PECU_CNT0_OFS = 8'h10;
	localparam int PECU_CH_N = 4;
	localparam int PECU_SRC_W = 5;
	localparam int PECU_SEL_STRIDE = 8;
	// Control fields
	localparam int PECU_CTRL_MODE_LSB = 0;
	localparam int PECU_CTRL_ARM_BIT = 4;
	localparam int PECU_CTRL_INIT_BIT = 5;
	// Status fields
	localparam int PECU_ST_COUNT_BIT = 0;
	localparam int PECU_ST_ERR_BIT = 1;
	localparam int PECU_ST_DONE_BIT = 2;
	localparam int PECU_ST_OVF_LSB = 4;
	localparam logic [31:0] PECU_ZERO = 32'h00000000;
	localparam logic [32:0] PECU_INC_ONE = 33'h000000001;
	localparam logic [32:0] PECU_INC_TWO = 33'h000000002;

	typedef enum logic [1:0] {
		PECU_MODE_RUN_BREAK,
		PECU_MODE_TRIG_FWD,
		PECU_MODE_TRIG_REV
	} pecu_mode_t;

	typedef enum logic [4:0] {
		PECU_SRC_DISABLED,
		PECU_SRC_ELAPSED_TIME,
		PECU_SRC_EXEC_STATES,
		PECU_SRC_BRANCH,
		PECU_SRC_INSTR,
		PECU_SRC_DSP_OP,
		PECU_SRC_FETCH_DATA_CONFLICT,
		PECU_SRC_OTHER_CONFLICT,
		PECU_SRC_EXCEPTION,
		PECU_SRC_OPERAND_TLB_MISS,
		PECU_SRC_FETCH_TLB_MISS,
		PECU_SRC_INTERRUPT,
		PECU_SRC_MASKED_STATE_INSTR,
		PECU_SRC_PRIVILEGED_INSTR,
		PECU_SRC_FETCH_CACHE_MISS,
		PECU_SRC_OPERAND_CACHE_MISS,
		PECU_SRC_FETCH_STALL,
		PECU_SRC_OPERAND_ACCESS_STALL,
		PECU_SRC_FETCH_MISS_STALL,
		PECU_SRC_OPERAND_MISS_STALL
	} pecu_src_t;

	localparam int PECU_EVT_N = 20;
endpackage : pecu_pkg

// ### tb/pecu_host.sv
// Emulator host model: APB master toward the counter unit
`timescale 1ns/1ps
module pecu_host (
	input wire logic CLK,
	output logic PSEL,
	output logic PENABLE,
	output logic PWRITE,
	output logic [7:0] PADDR,
	output logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY
);
	int tmo = 0;
	initial begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h00000000;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		q = PRDATA;
		tmo += (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : xfer
endmodule : pecu_host

// ### tb/test_perf_event_counter_unit.sv
// Self-checking bench for the performance event counter unit
`timescale 1ns/1ps
module test_perf_event_counter_unit;
	import pecu_pkg::*;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic [3:0] cue = 4'h0;
	logic [19:0] EVENTS = 20'h00000;
	wire logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, COUNTING;
	wire logic [7:0] PADDR;
	wire logic [31:0] PWDATA, PRDATA;
	logic [31:0] q;
	int errors = 0;
	int checks = 0;
	int seed = 32'hab0efed2;
	int exp_c[4];
	pecu_host h (.CLK(CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY));
	pecu_top DUT (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.RUN_START(cue[0]), .BREAK_HALT(cue[1]), .TRIG_A(cue[2]), .TRIG_B(cue[3]),
		.EVENTS(EVENTS), .COUNTING(COUNTING));
	task complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		h.xfer(w, a, d, q);
		if (h.tmo != 0) begin
			errors++;
			complete_run();
		end
	endtask : bus
	task pulse(input int k);
		@(posedge CLK);
		cue[k] <= 1'b1;
		@(posedge CLK);
		cue <= 4'h0;
	endtask : pulse
	// Events kept quiet at start and stop edges, where counts may be off by design
	task measure(input int r);
		int m, s;
		logic [31:0] sel, v;
		m = r % 3;
		sel = 32'h00000000;
		bus(1'b1, PECU_CTRL_OFS, 32'h00000020);
		for (int c = 0; c < 4; c++) begin
			bus(1'b0, 8'(PECU_CNT0_OFS + 4 * c), 32'h00000000);
			chk("cnt_clear", 32'h00000000, q);
			exp_c[c] = 0;
			sel[8*c +: 5] = 5'((4 * r + c) % 20);
		end
		bus(1'b1, PECU_SEL_OFS, sel);
		bus(1'b1, PECU_CTRL_OFS, 32'h00000010 | m);
		pulse(m == 0 ? 1 : (m == 1 ? 3 : 2));
		pulse(m == 0 ? 0 : (m == 1 ? 2 : 3));
		repeat (40) begin
			@(posedge CLK);
			v = $random(seed);
			EVENTS <= v[19:0];
			for (int c = 0; c < 4; c++) begin
				s = sel[8*c +: 5];
				if (s != 0 && v[s]) exp_c[c] += (s == 3) ? 2 : 1;
			end
		end
		chk("counting_on", 32'h00000001, {31'h0, COUNTING});
		@(posedge CLK);
		EVENTS <= 20'h00000;
		pulse(m == 0 ? 1 : (m == 1 ? 3 : 2));
		repeat (10) begin
			@(posedge CLK);
			EVENTS <= 20'($random(seed));
		end
		@(posedge CLK);
		EVENTS <= 20'h00000;
		chk("counting_off", 32'h00000000, {31'h0, COUNTING});
		bus(1'b0, PECU_STATUS_OFS, 32'h00000000);
		chk("status_done", 32'h00000004, q);
		for (int c = 0; c < 4; c++) begin
			bus(1'b0, 8'(PECU_CNT0_OFS + 4 * c), 32'h00000000);
			chk("cnt", 32'(exp_c[c]), q);
		end
	endtask : measure
	initial begin
		forever #50 CLK = ~CLK;
	end
	initial begin
		repeat (10) @(posedge CLK);
		SRST <= 1'b0;
		bus(1'b0, PECU_STATUS_OFS, 32'h00000000);
		chk("status_reset", 32'h00000000, q);
		bus(1'b0, 8'hFC, 32'h00000000);
		chk("unmapped", 32'h00000000, q);
		chk("pslverr", 32'h00000000, {31'h0, PSLVERR});
		for (int r = 0; r < 5; r++) measure(r);
		bus(1'b1, PECU_CTRL_OFS, 32'h00000003);
		bus(1'b0, PECU_CTRL_OFS, 32'h00000000);
		chk("mode_keep", 32'h00000001, {30'h0, q[1:0]});
		bus(1'b1, PECU_CTRL_OFS, 32'h00000020);
		bus(1'b1, PECU_SEL_OFS, 32'h00000000);
		bus(1'b1, PECU_CTRL_OFS, 32'h00000011);
		pulse(2);
		@(posedge CLK);
		chk("no_start", 32'h00000000, {31'h0, COUNTING});
		bus(1'b0, PECU_STATUS_OFS, 32'h00000000);
		chk("status_err", 32'h00000002, q);
		complete_run();
	end
endmodule : test_perf_event_counter_unit
